/* inc/dram_ctrl_pkg.sv */
package dram_ctrl_pkg;

  // Bus tracking states, presented as the five state variables
  typedef enum logic [4:0] {
    st_idle,
    st_row,
    st_col,
    st_acc,
    st_latch,
    st_ready,
    st_w_col,
    st_w_cs,
    st_pre
  } state_t;

  localparam int STATE_BITS = 5;
  localparam int BYTE_LANES = 8;

  // Delay for a delayed column clock; not used, col_path is clocked by i_sys_clk
  localparam int DELAYED_CLOCK_DELAY_NS = 20;
  localparam int CLK_PERIOD_NS = 8;

  // Row precharge: three idle clocks, counted 0..PRE_LAST
  localparam int PRE_CLKS = 3;
  localparam logic [1:0] PRE_LAST = 2'(PRE_CLKS - 1);
  localparam logic [1:0] PRE_ZERO = 2'h0;
  localparam logic [1:0] PRE_STEP = 2'h1;

  // Cache block fill: four reads counted by their ready answers
  localparam logic [2:0] FILL_READS = 3'h4;
  localparam logic [2:0] FILL_NONE = 3'h0;
  localparam logic [2:0] FILL_STEP = 3'h1;

  localparam logic [7:0] WE_OFF = 8'hff;

endpackage : dram_ctrl_pkg

/* inc/state_bus_if.sv */
`timescale 1ns/100ps
`default_nettype none

interface state_bus_if;
  dram_ctrl_pkg::state_t state_nxt;
  logic run_write;

  modport fsm (output state_nxt, output run_write);
  modport dec (input state_nxt, input run_write);
endinterface : state_bus_if

`default_nettype wire

/* logic/col_path.sv */
`timescale 1ns/100ps
`default_nettype none

module col_path (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  state_bus_if.dec sb,
  output logic o_col_addr_drive_en_n,
  output logic o_col_addr_latch_n,
  output logic o_master_chip_select_n,
  output logic o_read_data_latch,
  output logic o_write_data_latch
);

  dram_ctrl_pkg::state_t s;
  logic col_on;
  logic cs_on;

  // Decodes the state as it is produced, so the column path acts in the same clock
  always_comb begin
    s = sb.state_nxt; // R5
    col_on = (s == dram_ctrl_pkg::st_col) || (s == dram_ctrl_pkg::st_acc) ||
             (s == dram_ctrl_pkg::st_latch) || (s == dram_ctrl_pkg::st_ready) ||
             (s == dram_ctrl_pkg::st_w_col) || (s == dram_ctrl_pkg::st_w_cs);
    // Early write: chip select only after ready, so data and write enables lead it
    cs_on = sb.run_write ? (s == dram_ctrl_pkg::st_w_cs) : col_on; // R23
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_sys_clk or negedge i_rst) begin
    if (!i_rst) begin
      o_col_addr_drive_en_n <= 1'b1;
      o_col_addr_latch_n <= 1'b1;
      o_master_chip_select_n <= 1'b1;
      o_read_data_latch <= 1'b0;
      o_write_data_latch <= 1'b0;
    end else begin
      o_col_addr_drive_en_n <= !col_on; // R9 R17
      o_col_addr_latch_n <= !((s == dram_ctrl_pkg::st_col) || (s == dram_ctrl_pkg::st_w_col)); // R10 R17
      o_master_chip_select_n <= !cs_on; // R10 R17
      o_read_data_latch <= (s == dram_ctrl_pkg::st_latch); // R11
      o_write_data_latch <= (s == dram_ctrl_pkg::st_w_col); // R20 R21
    end
  end

  ////////////////////////////////////////////////////////////////////////
  property p_rdl_after_cae;
    @(posedge i_sys_clk) disable iff (!i_rst)
    ($fell(o_col_addr_drive_en_n) && !sb.run_write) |-> ##2 o_read_data_latch;
  endproperty
  a_rdl_after_cae: assert property (p_rdl_after_cae) else $error("read latch not two clocks after column enable"); // R11

endmodule : col_path

`default_nettype wire

/* logic/byte_lane_reg.sv */
`timescale 1ns/100ps
`default_nettype none

module byte_lane_reg #(
  parameter int LANES = dram_ctrl_pkg::BYTE_LANES
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_strobe,
  input wire logic i_release,
  input wire logic [LANES-1:0] i_byte_lane_enables_n,
  output logic [LANES-1:0] o_byte_write_en_n
);

  // One latch per byte lane; strobe only arrives in write cycles
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    always_ff @(posedge i_sys_clk or negedge i_rst) begin
      if (!i_rst) begin
        o_byte_write_en_n[g] <= 1'b1;
      end else if (i_strobe) begin
        o_byte_write_en_n[g] <= i_byte_lane_enables_n[g]; // R1 R22
      end else if (i_release) begin
        o_byte_write_en_n[g] <= 1'b1;
      end
    end
  end

  property p_lanes_capture;
    @(posedge i_sys_clk) disable iff (!i_rst)
    i_strobe |=> (o_byte_write_en_n == $past(i_byte_lane_enables_n));
  endproperty
  a_lanes_capture: assert property (p_lanes_capture) else $error("byte lane enables not captured"); // R1

endmodule : byte_lane_reg

`default_nettype wire

/* logic/dram_cycle_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none

// Contract
// (R1) Byte-enable latch strobe pulses only in writes
// (R2) Latch address strobe, hold exactly one clock
// (R3) Strobe end with region hit sets waiting
// (R4) Clear strobe drops waiting flag when taken
// (R5) Column path acts on state same clock
// (R6) State shown as five state variables
// (R7) Hold asserted while pipelined cycles outstanding
// (R8) Row drive on until one after row strobe
// (R9) Column drive enables as row drive disables
// (R10) Column latch and chip select with column
// (R11) Read latch two clocks after column enable
// (R12) Ready after latch, drop, three precharge clocks
// (R13) Cacheable with next-address makes four-read fill
// (R14) Next-address every read, three pending maximum
// (R15) First read: next-address at ready-3, ready-1
// (R16) Processor strobes after next-address when pending
// (R17) Same page: column, row, select stay on
// (R18) No new cycle right after next-address
// (R19) Row change drops row strobe, ends pipeline
// (R20) Writes posted, ready before DRAM write
// (R21) Write: row strobe, then column with latches
// (R22) Byte write enables the clock after strobe
// (R23) Chip select one clock after write ready
// (R24) Ready and next-address can release the bus
// (R25) Reset: idle, strobes off, flag clear

module dram_cycle_ctrl #(
  parameter int LANES = dram_ctrl_pkg::BYTE_LANES
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_cpu_address_strobe_n,
  input wire logic i_write,
  input wire logic i_dram_region_hit,
  input wire logic i_same_row,
  input wire logic i_cacheable_indicator_n,
  input wire logic [LANES-1:0] i_byte_lane_enables_n,
  output logic o_cycle_done_to_cpu_n,
  output logic o_cycle_done_oe,
  output logic o_next_address_request_n,
  output logic o_next_address_oe,
  output logic o_pipeline_hold_n,
  output logic [dram_ctrl_pkg::STATE_BITS-1:0] o_state_variables,
  output logic o_latched_cycle_strobe_n,
  output logic o_cycle_waiting_flag_n,
  output logic o_clear_waiting_flag,
  output logic o_row_addr_drive_en_n,
  output logic o_row_strobe_n,
  output logic o_col_addr_drive_en_n,
  output logic o_col_addr_latch_n,
  output logic o_master_chip_select_n,
  output logic o_read_data_latch,
  output logic o_write_data_latch,
  output logic o_byte_enable_latch_strobe,
  output logic [LANES-1:0] o_byte_write_en_n
);

  logic rst_meta_r;
  logic rst_sync_r;
  logic latched_cycle_strobe_r;
  logic waiting_r;
  logic cyc_write_r;
  logic run_write_r;
  logic run_write_nxt;
  logic clr_nxt;
  logic release_r;
  logic [1:0] pre_cnt_r;
  logic [1:0] pre_cnt_nxt;
  logic [2:0] fill_r;
  logic [2:0] fill_nxt;
  logic waiting_nxt;
  logic busy_nxt;
  dram_ctrl_pkg::state_t state_r;
  dram_ctrl_pkg::state_t state_nxt;

  state_bus_if sb ();

  ////////////////////////////////////////////////////////////////////////
  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address strobe is caught a clock late; the address is only valid then
  always_ff @(posedge i_sys_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      latched_cycle_strobe_r <= 1'b0;
      cyc_write_r <= 1'b0;
    end else begin
      latched_cycle_strobe_r <= !i_cpu_address_strobe_n && !latched_cycle_strobe_r; // R2
      if (latched_cycle_strobe_r) begin
        cyc_write_r <= i_write;
      end
    end
  end

  assign o_latched_cycle_strobe_n = !latched_cycle_strobe_r;

  // A new strobe beats a clear in the same clock
  always_comb begin
    waiting_nxt = (latched_cycle_strobe_r && i_dram_region_hit) || (waiting_r && !clr_nxt); // R3 R4
  end

  always_ff @(posedge i_sys_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      waiting_r <= 1'b0;
      o_clear_waiting_flag <= 1'b0;
    end else begin
      waiting_r <= waiting_nxt; // R3 R4
      o_clear_waiting_flag <= clr_nxt; // R4
    end
  end

  assign o_cycle_waiting_flag_n = !waiting_r;

  ////////////////////////////////////////////////////////////////////////
  // Bus tracking state machine
  always_comb begin
    state_nxt = state_r;
    clr_nxt = 1'b0;
    pre_cnt_nxt = pre_cnt_r;
    run_write_nxt = run_write_r;
    unique case (state_r)
      dram_ctrl_pkg::st_idle: begin
        if (waiting_r) begin
          clr_nxt = 1'b1; // R4
          run_write_nxt = cyc_write_r;
          state_nxt = dram_ctrl_pkg::st_row; // R8 R21
        end
      end
      dram_ctrl_pkg::st_row: begin
        state_nxt = run_write_r ? dram_ctrl_pkg::st_w_col : dram_ctrl_pkg::st_col; // R9 R21
      end
      dram_ctrl_pkg::st_col: state_nxt = dram_ctrl_pkg::st_acc;
      dram_ctrl_pkg::st_acc: state_nxt = dram_ctrl_pkg::st_latch;
      dram_ctrl_pkg::st_latch: state_nxt = dram_ctrl_pkg::st_ready; // R12
      dram_ctrl_pkg::st_ready: begin
        // Only same-page reads continue; a page change or a write turns
        // around through precharge and is taken up from idle
        if (waiting_r && !cyc_write_r && i_same_row) begin
          clr_nxt = 1'b1; // R4
          state_nxt = dram_ctrl_pkg::st_col; // R17
        end else begin
          state_nxt = dram_ctrl_pkg::st_pre; // R12 R18 R19
        end
      end
      dram_ctrl_pkg::st_w_col: state_nxt = dram_ctrl_pkg::st_w_cs; // R20 R23
      dram_ctrl_pkg::st_w_cs: state_nxt = dram_ctrl_pkg::st_pre;
      dram_ctrl_pkg::st_pre: begin
        if (pre_cnt_r == dram_ctrl_pkg::PRE_LAST) begin
          pre_cnt_nxt = dram_ctrl_pkg::PRE_ZERO;
          state_nxt = dram_ctrl_pkg::st_idle; // R12
        end else begin
          pre_cnt_nxt = pre_cnt_r + dram_ctrl_pkg::PRE_STEP;
        end
      end
      default: state_nxt = dram_ctrl_pkg::st_idle;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      state_r <= dram_ctrl_pkg::st_idle; // R25
      pre_cnt_r <= dram_ctrl_pkg::PRE_ZERO;
      run_write_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pre_cnt_r <= pre_cnt_nxt;
      run_write_r <= run_write_nxt;
    end
  end

  assign o_state_variables = state_r; // R6
  assign sb.state_nxt = state_nxt;
  assign sb.run_write = run_write_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Row path and processor answers, registered from the next state
  always_comb begin
    busy_nxt = (state_nxt != dram_ctrl_pkg::st_idle) && (state_nxt != dram_ctrl_pkg::st_pre);
  end

  always_ff @(posedge i_sys_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      o_row_strobe_n <= 1'b1;
      o_row_addr_drive_en_n <= 1'b0;
      o_cycle_done_to_cpu_n <= 1'b1;
      o_cycle_done_oe <= 1'b0;
      o_next_address_request_n <= 1'b1;
      o_next_address_oe <= 1'b0;
    end else begin
      o_row_strobe_n <= !busy_nxt; // R12 R17 R19
      o_row_addr_drive_en_n <= !((state_nxt == dram_ctrl_pkg::st_idle) ||
                                 (state_nxt == dram_ctrl_pkg::st_row) ||
                                 (state_nxt == dram_ctrl_pkg::st_pre)); // R8 R9
      o_cycle_done_to_cpu_n <= !((state_nxt == dram_ctrl_pkg::st_ready) ||
                                 (state_nxt == dram_ctrl_pkg::st_w_col)); // R12 R20
      // Early next-address only in a read started from idle; pipelined reads ask once,
      // so no more than one cycle waits behind the one in progress
      o_next_address_request_n <= !(((state_nxt == dram_ctrl_pkg::st_col) && (state_r == dram_ctrl_pkg::st_row)) ||
                                    (state_nxt == dram_ctrl_pkg::st_latch)); // R14 R15
      // Bus released whenever no DRAM cycle owns it
      o_cycle_done_oe <= busy_nxt || waiting_nxt || (fill_nxt != dram_ctrl_pkg::FILL_NONE); // R24
      o_next_address_oe <= busy_nxt || waiting_nxt || (fill_nxt != dram_ctrl_pkg::FILL_NONE); // R24
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Cache fill tracking; counts the ready answers still owed to the fill
  always_comb begin
    fill_nxt = fill_r;
    if (!o_next_address_request_n && !i_cacheable_indicator_n && (fill_r == dram_ctrl_pkg::FILL_NONE)) begin
      fill_nxt = dram_ctrl_pkg::FILL_READS; // R13
    end else if (!o_cycle_done_to_cpu_n && !run_write_r && (fill_r != dram_ctrl_pkg::FILL_NONE)) begin
      fill_nxt = fill_r - dram_ctrl_pkg::FILL_STEP;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      fill_r <= dram_ctrl_pkg::FILL_NONE;
      o_pipeline_hold_n <= 1'b1;
    end else begin
      fill_r <= fill_nxt; // R13
      o_pipeline_hold_n <= !((fill_nxt != dram_ctrl_pkg::FILL_NONE) || waiting_nxt); // R7
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Byte enables latched the clock after the strobe, released after chip select
  always_ff @(posedge i_sys_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      o_byte_enable_latch_strobe <= 1'b0;
      release_r <= 1'b0;
    end else begin
      o_byte_enable_latch_strobe <= latched_cycle_strobe_r && i_write; // R1 R22
      release_r <= (state_r == dram_ctrl_pkg::st_w_cs);
    end
  end

  byte_lane_reg #(.LANES(LANES)) u_lanes (
    .i_sys_clk(i_sys_clk),
    .i_rst(rst_sync_r),
    .i_strobe(o_byte_enable_latch_strobe),
    .i_release(release_r),
    .i_byte_lane_enables_n(i_byte_lane_enables_n),
    .o_byte_write_en_n(o_byte_write_en_n)
  );

  col_path u_col (
    .i_sys_clk(i_sys_clk),
    .i_rst(rst_sync_r),
    .sb(sb.dec),
    .o_col_addr_drive_en_n(o_col_addr_drive_en_n),
    .o_col_addr_latch_n(o_col_addr_latch_n),
    .o_master_chip_select_n(o_master_chip_select_n),
    .o_read_data_latch(o_read_data_latch),
    .o_write_data_latch(o_write_data_latch)
  );

  ////////////////////////////////////////////////////////////////////////
  property p_latched_cycle_strobe_cause;
    @(posedge i_sys_clk) disable iff (!rst_sync_r)
    latched_cycle_strobe_r |-> $past(!i_cpu_address_strobe_n) ##1 !latched_cycle_strobe_r;
  endproperty
  a_latched_cycle_strobe_cause: assert property (p_latched_cycle_strobe_cause) else $error("latched strobe without cause or too long"); // R2

  property p_wait_set;
    @(posedge i_sys_clk) disable iff (!rst_sync_r)
    (latched_cycle_strobe_r && i_dram_region_hit) |=> !o_cycle_waiting_flag_n;
  endproperty
  a_wait_set: assert property (p_wait_set) else $error("waiting flag not set"); // R3

  property p_wait_clr;
    @(posedge i_sys_clk) disable iff (!rst_sync_r)
    (o_clear_waiting_flag && !$past(latched_cycle_strobe_r && i_dram_region_hit)) |-> o_cycle_waiting_flag_n;
  endproperty
  a_wait_clr: assert property (p_wait_clr) else $error("waiting flag not cleared"); // R4

  property p_row_drive;
    @(posedge i_sys_clk) disable iff (!rst_sync_r)
    $fell(o_row_strobe_n) |-> !o_row_addr_drive_en_n ##1 o_row_addr_drive_en_n;
  endproperty
  a_row_drive: assert property (p_row_drive) else $error("row drive not held one clock past row strobe"); // R8

  property p_col_swap;
    @(posedge i_sys_clk) disable iff (!rst_sync_r)
    $rose(o_row_addr_drive_en_n) |-> $fell(o_col_addr_drive_en_n);
  endproperty
  a_col_swap: assert property (p_col_swap) else $error("column drive not enabled with row drive off"); // R9

  property p_col_start;
    @(posedge i_sys_clk) disable iff (!rst_sync_r)
    ($fell(o_col_addr_drive_en_n) && !run_write_r) |-> (!o_col_addr_latch_n && !o_master_chip_select_n);
  endproperty
  a_col_start: assert property (p_col_start) else $error("column latch or select missing"); // R10

  property p_precharge;
    @(posedge i_sys_clk) disable iff (!rst_sync_r)
    (!o_cycle_done_to_cpu_n && (state_nxt == dram_ctrl_pkg::st_pre)) |=> o_row_strobe_n [*3];
  endproperty
  a_precharge: assert property (p_precharge) else $error("precharge shorter than three clocks"); // R12

  property p_na_lead;
    @(posedge i_sys_clk) disable iff (!rst_sync_r)
    (!o_next_address_request_n && (state_r == dram_ctrl_pkg::st_col)) |-> ##2 !o_next_address_request_n ##1 !o_cycle_done_to_cpu_n;
  endproperty
  a_na_lead: assert property (p_na_lead) else $error("next-address not at ready-3 and ready-1"); // R15

  property p_early_write;
    @(posedge i_sys_clk) disable iff (!rst_sync_r)
    (!o_cycle_done_to_cpu_n && run_write_r) |=> (!o_master_chip_select_n && !o_write_data_latch);
  endproperty
  a_early_write: assert property (p_early_write) else $error("chip select not one clock after write ready"); // R23

  property p_hold;
    @(posedge i_sys_clk) disable iff (!rst_sync_r)
    !o_cycle_waiting_flag_n |-> (!o_pipeline_hold_n && o_cycle_done_oe);
  endproperty
  a_hold: assert property (p_hold) else $error("hold dropped with a cycle waiting"); // R7

endmodule : dram_cycle_ctrl

`default_nettype wire

/* tb/cpu_bus_model.sv */
`timescale 1ns/100ps
`default_nettype none

module cpu_bus_model (
  input wire logic i_sys_clk,
  input wire logic i_next_address_request_n,
  input wire logic i_next_address_oe,
  output logic o_address_strobe_n,
  output logic o_write,
  output logic o_cacheable_n,
  output logic [7:0] o_byte_lanes_n
);
  int left = 0;
  logic go_next = 1'b0;

  initial begin
    o_address_strobe_n = 1'b1;
    o_write = 1'b0;
    o_cacheable_n = 1'b1;
    o_byte_lanes_n = 8'hff;
  end

  // Called after this model's own post-edge update, so the next edge releases the strobe
  task automatic start(input logic wr, input logic fill, input logic [7:0] be);
    o_write = wr;
    o_cacheable_n = ~fill;
    o_byte_lanes_n = be;
    left = fill ? 3 : 0;
    o_address_strobe_n = 1'b0;
  endtask : start

  // Strobe lasts one clock; a pipelined strobe follows a seen next-address by one clock
  always @(posedge i_sys_clk) begin
    #1;
    o_address_strobe_n = ~go_next;
    go_next = (i_next_address_request_n === 1'b0) && (i_next_address_oe === 1'b1) && (left > 0);
    if (go_next)
      left--;
  end
endmodule : cpu_bus_model

`default_nettype wire

/* tb/pipelined_dram_cycle_controller_bench.sv */
`timescale 1ns/100ps
`default_nettype none

module pipelined_dram_cycle_controller_bench;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic hit = 1'b1;
  logic same_row = 1'b1;
  logic ads_n, wr, ken_n;
  logic [7:0] be_n, we_n;
  logic rdy_n, rdy_oe, na_n, na_oe, hold_n, latched_cycle_strobe_n, wait_n, clr, rae_n, ras_n;
  logic cae_n, cal_n, cs_n, read_data_latch, write_data_latch, byte_enable_latch_strobe;
  logic [4:0] st;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;

  initial begin
    forever #4 i_sys_clk = ~i_sys_clk;
  end

  cpu_bus_model bus (.i_sys_clk(i_sys_clk), .i_next_address_request_n(na_n), .i_next_address_oe(na_oe),
    .o_address_strobe_n(ads_n), .o_write(wr), .o_cacheable_n(ken_n), .o_byte_lanes_n(be_n));

  dram_cycle_ctrl DUT (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_cpu_address_strobe_n(ads_n),
    .i_write(wr), .i_dram_region_hit(hit), .i_same_row(same_row), .i_cacheable_indicator_n(ken_n),
    .i_byte_lane_enables_n(be_n), .o_cycle_done_to_cpu_n(rdy_n), .o_cycle_done_oe(rdy_oe),
    .o_next_address_request_n(na_n), .o_next_address_oe(na_oe), .o_pipeline_hold_n(hold_n),
    .o_state_variables(st), .o_latched_cycle_strobe_n(latched_cycle_strobe_n), .o_cycle_waiting_flag_n(wait_n),
    .o_clear_waiting_flag(clr), .o_row_addr_drive_en_n(rae_n), .o_row_strobe_n(ras_n),
    .o_col_addr_drive_en_n(cae_n), .o_col_addr_latch_n(cal_n), .o_master_chip_select_n(cs_n),
    .o_read_data_latch(read_data_latch), .o_write_data_latch(write_data_latch), .o_byte_enable_latch_strobe(byte_enable_latch_strobe),
    .o_byte_write_en_n(we_n));

  ////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  // Whole run needs about 115 clocks
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Drives and samples share one offset after the edge; registered outputs are settled by then
  task automatic tick();
    @(posedge i_sys_clk);
    #2;
  endtask : tick

  task automatic test_reset();
    chk("state", st, 8'h00);
    chk("row strobe", ras_n, 1'b1);
    chk("select", cs_n, 1'b1);
    chk("waiting", wait_n, 1'b1);
    chk("ready oe", rdy_oe, 1'b0);
    $display("test reset done");
  endtask : test_reset

  task automatic test_read();
    tick();
    bus.start(1'b0, 1'b0, 8'hff);
    for (int k = 1; k <= 11; k++) begin
      tick();
      chk("wel", byte_enable_latch_strobe, 1'b0);
      case (k)
        1: chk("latched_cycle_strobe", latched_cycle_strobe_n, 1'b0);
        2: chk("waiting", wait_n, 1'b0);
        3: begin
          chk("clear", clr, 1'b1);
          chk("waiting", wait_n, 1'b1);
          chk("row strobe", ras_n, 1'b0);
          chk("row drive", rae_n, 1'b0);
          chk("state", st, 8'h01);
        end
        4: begin
          chk("row drive", rae_n, 1'b1);
          chk("col drive", cae_n, 1'b0);
          chk("col latch", cal_n, 1'b0);
          chk("select", cs_n, 1'b0);
          chk("next addr", na_n, 1'b0);
        end
        5: chk("next addr", na_n, 1'b1);
        6: begin
          chk("read latch", read_data_latch, 1'b1);
          chk("next addr", na_n, 1'b0);
        end
        7: chk("ready", rdy_n, 1'b0);
        8: begin
          chk("row strobe", ras_n, 1'b1);
          chk("select", cs_n, 1'b1);
        end
        10: chk("state", st, 8'h08);
        11: begin
          chk("state", st, 8'h00);
          chk("ready oe", rdy_oe, 1'b0);
        end
        default: ;
      endcase
    end
    $display("test read done");
  endtask : test_read

  task automatic test_write(input logic [7:0] be);
    tick();
    bus.start(1'b1, 1'b0, be);
    for (int k = 1; k <= 6; k++) begin
      tick();
      case (k)
        1: chk("wel", byte_enable_latch_strobe, 1'b0);
        2: chk("wel", byte_enable_latch_strobe, 1'b1);
        3: begin
          chk("lane enables", we_n, be);
          chk("row strobe", ras_n, 1'b0);
          chk("select", cs_n, 1'b1);
        end
        4: begin
          chk("col drive", cae_n, 1'b0);
          chk("write latch", write_data_latch, 1'b1);
          chk("ready", rdy_n, 1'b0);
        end
        5: chk("select", cs_n, 1'b0);
        default: ;
      endcase
    end
    repeat (6) tick();
    $display("test write done");
  endtask : test_write

  task automatic test_fill();
    int rdy = 0;
    int first = 0;
    int gap = 0;
    int early = 0;
    logic [63:0] na = '0;
    tick();
    bus.start(1'b0, 1'b1, 8'hff);
    for (int k = 1; k < 64; k++) begin
      tick();
      na[k] = (na_n === 1'b0);
      if (rdy_n === 1'b0 && rdy_oe === 1'b1) begin
        rdy++;
        if (first == 0)
          first = k;
      end
      if (first == 0 && na[k])
        early++;
      if (k >= 4 && rdy < 4 && cs_n !== 1'b0)
        gap++;
      if (k == 8)
        chk("hold", hold_n, 1'b0);
    end
    chk("readies", 8'(rdy), 8'h04);
    chk("na before ready", 8'(early), 8'h02);
    chk("na ready-3", na[first - 3], 1'b1);
    chk("na ready-1", na[first - 1], 1'b1);
    chk("select gaps", 8'(gap), 8'h00);
    chk("state", st, 8'h00);
    $display("test fill done");
  endtask : test_fill

  task automatic test_miss();
    tick();
    hit = 1'b0;
    bus.start(1'b0, 1'b0, 8'hff);
    repeat (6) begin
      tick();
      chk("waiting", wait_n, 1'b1);
      chk("state", st, 8'h00);
    end
    hit = 1'b1;
    $display("test miss done");
  endtask : test_miss

  initial begin
    repeat (2) tick();
    i_rst_n = 1'b1;
    repeat (4) tick();
    test_reset();
    test_read();
    test_write(8'h5a);
    test_write(8'h01);
    test_fill();
    test_miss();
    tally_and_finish();
  end
endmodule : pipelined_dram_cycle_controller_bench

`default_nettype wire
